// *** rtl/rpr_result_regs.sv ***
// Ranging and phase result registers behind an AHB-Lite slave.
`timescale 1ns/100ps
module rpr_result_regs
    import rpr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sync_peak,
    input wire logic [7:0] corr_mag,
    input wire logic header_detect,
    input wire logic frame_end,
    input wire logic [7:0] freq_offset_value,
    input wire logic flight_start,
    input wire logic flight_stop,
    input wire logic rx_phase,
    input wire logic ref_phase,
    output logic phase_unit_enable,
    output logic phase_if_invert
);
    typedef struct packed {
        logic [1:0] rx_sync;
        logic [1:0] ref_sync;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [7:0] ctrl;
        logic [7:0] fec;
        logic [23:0] flight;
        logic timing;
        logic [31:0] tick_acc;
        logic [11:0] ph_cnt;
        logic [7:0] ph_acc;
        logic [7:0] phase;
        logic [31:0] rdata;
        logic en_o;
        logic inv_o;
    } rpr_state_t;
    rpr_state_t st_reg;
    rpr_state_t st_next;
    logic [7:0] cpm500;
    logic [7:0] cpm750;
    logic [7:0] cpm1000;
    logic [7:0] raddr;
    logic addr_ok;
    logic view;
    logic [7:0] rd_byte;
    logic mism;

    rpr_sample_tap #(.DELAY(RPR_SAMP_CYC_0)) u_tap500 (
        .hclk(hclk),
        .hresetn(hresetn),
        .peak(sync_peak),
        .mag(corr_mag),
        .sample(cpm500)
    );

    rpr_sample_tap #(.DELAY(RPR_SAMP_CYC_1)) u_tap750 (
        .hclk(hclk),
        .hresetn(hresetn),
        .peak(sync_peak),
        .mag(corr_mag),
        .sample(cpm750)
    );

    rpr_sample_tap #(.DELAY(RPR_SAMP_CYC_2)) u_tap1000 (
        .hclk(hclk),
        .hresetn(hresetn),
        .peak(sync_peak),
        .mag(corr_mag),
        .sample(cpm1000)
    );

    assign raddr = haddr[9:2];
    assign addr_ok = hsel && hready && htrans[1];
    assign view = st_reg.ctrl[RPR_BIT_VIEW];
    // The reference and received phases arrive from the analog side, so they are resampled.
    assign mism = st_reg.rx_sync[1] ^ (st_reg.ref_sync[1] ^ st_reg.ctrl[RPR_BIT_IF_INV]); // RULE_08

    always_comb begin
        rd_byte = 8'h00;
        unique case (raddr)
            RPR_OFS_CTRL: rd_byte = st_reg.ctrl;
            RPR_OFS_PHASE: rd_byte = st_reg.phase;
            RPR_OFS_CPM500: rd_byte = view ? cpm500 : 8'h00; // RULE_12
            RPR_OFS_CPM750: rd_byte = view ? cpm750 : 8'h00;
            RPR_OFS_CPM1000: rd_byte = view ? cpm1000 : 8'h00;
            RPR_OFS_FEC: rd_byte = view ? st_reg.fec : 8'h00;
            RPR_OFS_TIM0: rd_byte = view ? st_reg.flight[7:0] : 8'h00; // RULE_06
            RPR_OFS_TIM1: rd_byte = view ? st_reg.flight[15:8] : 8'h00;
            RPR_OFS_TIM2: rd_byte = view ? st_reg.flight[23:16] : 8'h00;
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        st_next.rx_sync = {st_reg.rx_sync[0], rx_phase};
        st_next.ref_sync = {st_reg.ref_sync[0], ref_phase};
        st_next.wr_pend = 1'b0;
        if (addr_ok) begin
            st_next.rdata = {24'h000000, rd_byte};
            st_next.wr_pend = hwrite;
            st_next.wr_addr = raddr;
        end
        // Only the control register takes writes; result addresses drop them.
        if (st_reg.wr_pend && st_reg.wr_addr == RPR_OFS_CTRL) begin // RULE_12
            st_next.ctrl = hwdata[7:0] & RPR_CTRL_WMASK; // RULE_09 RULE_10
        end
        st_next.en_o = st_next.ctrl[RPR_BIT_PHASE_EN];
        st_next.inv_o = st_next.ctrl[RPR_BIT_IF_INV];
        if (frame_end) begin
            st_next.fec = freq_offset_value; // RULE_04 RULE_05
        end else if (header_detect) begin
            st_next.fec = freq_offset_value; // RULE_03
        end
        // Fractional accumulator gives an average 16 MHz tick from the 250 MHz clock.
        if (st_reg.timing) begin
            if (st_reg.tick_acc + 32'd1000 >= 32'(RPR_TICK_MILLI)) begin
                st_next.tick_acc = st_reg.tick_acc + 32'd1000 - 32'(RPR_TICK_MILLI);
                st_next.flight = st_reg.flight + 24'h000001; // RULE_07
            end else begin
                st_next.tick_acc = st_reg.tick_acc + 32'd1000;
            end
            if (flight_stop) begin
                st_next.timing = 1'b0;
            end
        end
        if (flight_start) begin
            st_next.timing = 1'b1;
            st_next.flight = 24'h000000;
            st_next.tick_acc = 32'h00000000;
        end
        // Phase is the share of a window where the two signs disagree, 0..250 covers 0..360.
        if (st_reg.ctrl[RPR_BIT_PHASE_EN]) begin
            if (st_reg.ph_cnt == 12'(RPR_PHASE_CYC - 1)) begin
                st_next.ph_cnt = 12'h000;
                st_next.phase = st_reg.ph_acc; // RULE_11
                st_next.ph_acc = 8'h00;
            end else begin
                st_next.ph_cnt = st_reg.ph_cnt + 12'h001;
                if (mism && st_reg.ph_cnt[2:0] == 3'h0) begin
                    st_next.ph_acc = st_reg.ph_acc + 8'h01; // RULE_08
                end
            end
        end else begin
            st_next.ph_cnt = 12'h000;
            st_next.ph_acc = 8'h00;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
            st_reg.ctrl <= RPR_CTRL_RESET; // RULE_09 RULE_10
        end else begin
            st_reg <= st_next;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_reg.rdata;
    assign phase_unit_enable = st_reg.en_o;
    assign phase_if_invert = st_reg.inv_o;

    a_phase_period: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
        (st_reg.ph_cnt != 12'h000 && st_reg.ph_cnt != 12'(RPR_PHASE_CYC - 1)) |=> $stable(st_reg.phase))
        else $error("phase result changed mid window");
    a_fec_end: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
        frame_end |=> st_reg.fec == $past(freq_offset_value))
        else $error("frequency offset not taken at frame end");
    a_fec_hdr: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
        (header_detect && !frame_end) |=> st_reg.fec == $past(freq_offset_value))
        else $error("frequency offset not taken at header");
    a_view_hide: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        (addr_ok && !hwrite && !view && raddr == RPR_OFS_FEC) |=> hrdata == 32'h0)
        else $error("result visible without view enable");
    a_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
        (st_reg.wr_pend && st_reg.wr_addr == RPR_OFS_CTRL) |=>
        phase_unit_enable == $past(hwdata[RPR_BIT_PHASE_EN]))
        else $error("phase enable not written");
    a_if_inv: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
        phase_if_invert == st_reg.ctrl[RPR_BIT_IF_INV])
        else $error("inverse bit output mismatch");
    a_ro_result: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        (st_reg.wr_pend && st_reg.wr_addr != RPR_OFS_CTRL) |=> $stable(st_reg.ctrl))
        else $error("write to result register took effect");
    a_flight_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
        (!st_reg.timing && !flight_start) |=> $stable(st_reg.flight))
        else $error("flight count moved while idle");
    a_phase_off: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
        !st_reg.ctrl[RPR_BIT_PHASE_EN] |=> $stable(st_reg.phase))
        else $error("phase updated while disabled");

    a_okay_resp: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        hresp == 1'b0)
        else $error("error response seen");

    a_ready_high: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        hreadyout == 1'b1)
        else $error("wait state inserted");

    a_rdata_upper: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
        hrdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    a_ctrl_bit6: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
        st_reg.ctrl[6] == 1'b0)
        else $error("reserved control bit set");

    a_en_mirror: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
        phase_unit_enable == st_reg.ctrl[RPR_BIT_PHASE_EN])
        else $error("phase enable output mismatch");

    a_ctrl_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        !(st_reg.wr_pend && st_reg.wr_addr == RPR_OFS_CTRL) |=> $stable(st_reg.ctrl))
        else $error("control changed without write");

    a_view_hide_c500: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        (addr_ok && !view && raddr == RPR_OFS_CPM500) |=> hrdata == 32'h0)
        else $error("sample visible without view enable");

    a_view_hide_c750: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        (addr_ok && !view && raddr == RPR_OFS_CPM750) |=> hrdata == 32'h0)
        else $error("sample visible without view enable");

    a_view_hide_c1000: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        (addr_ok && !view && raddr == RPR_OFS_CPM1000) |=> hrdata == 32'h0)
        else $error("sample visible without view enable");

    a_view_hide_t0: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        (addr_ok && !view && raddr == RPR_OFS_TIM0) |=> hrdata == 32'h0)
        else $error("flight time visible without view enable");

    a_view_hide_t1: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        (addr_ok && !view && raddr == RPR_OFS_TIM1) |=> hrdata == 32'h0)
        else $error("flight time visible without view enable");

    a_view_hide_t2: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        (addr_ok && !view && raddr == RPR_OFS_TIM2) |=> hrdata == 32'h0)
        else $error("flight time visible without view enable");

    a_view_show_fec: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
        (addr_ok && view && raddr == RPR_OFS_FEC) |=> hrdata[7:0] == $past(st_reg.fec))
        else $error("frequency offset read wrong");

    a_view_show_t0: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
        (addr_ok && view && raddr == RPR_OFS_TIM0) |=> hrdata[7:0] == $past(st_reg.flight[7:0]))
        else $error("flight low byte read wrong");

    a_view_show_t1: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
        (addr_ok && view && raddr == RPR_OFS_TIM1) |=> hrdata[7:0] == $past(st_reg.flight[15:8]))
        else $error("flight mid byte read wrong");

    a_view_show_t2: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
        (addr_ok && view && raddr == RPR_OFS_TIM2) |=> hrdata[7:0] == $past(st_reg.flight[23:16]))
        else $error("flight high byte read wrong");

    a_phase_read: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
        (addr_ok && raddr == RPR_OFS_PHASE) |=> hrdata[7:0] == $past(st_reg.phase))
        else $error("phase result read wrong");

    a_ctrl_read: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
        (addr_ok && raddr == RPR_OFS_CTRL) |=> hrdata[7:0] == $past(st_reg.ctrl))
        else $error("control read wrong");

    a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        !addr_ok |=> $stable(hrdata))
        else $error("read data changed without transfer");

    a_flight_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
        flight_start |=> st_reg.flight == 24'h000000)
        else $error("flight count not cleared at start");

    a_flight_step: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
        (st_reg.timing && !flight_start) |=> (st_reg.flight - $past(st_reg.flight)) <= 24'h000001)
        else $error("flight count jumped");

    a_flight_stop: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
        (st_reg.timing && flight_stop && !flight_start) |=> !st_reg.timing)
        else $error("flight count did not stop");

    a_phase_idle: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
        !st_reg.ctrl[RPR_BIT_PHASE_EN] |=> st_reg.ph_cnt == 12'h000)
        else $error("phase window ran while disabled");

    a_phase_cnt_max: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
        st_reg.ph_cnt <= 12'(RPR_PHASE_CYC - 1))
        else $error("phase window overran");

    a_phase_step: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
        (st_reg.ctrl[RPR_BIT_PHASE_EN] && st_reg.ph_cnt == 12'(RPR_PHASE_CYC - 1)) |=>
        st_reg.phase == $past(st_reg.ph_acc))
        else $error("phase result not refreshed at window end");

    a_acc_limit: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_08
        st_reg.ph_acc <= 8'(RPR_PHASE_CYC / 8))
        else $error("phase accumulator beyond window");

    a_tick_bound: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
        st_reg.tick_acc < 32'(RPR_TICK_MILLI))
        else $error("tick accumulator out of range");

    a_fec_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
        (!frame_end && !header_detect) |=> $stable(st_reg.fec))
        else $error("frequency offset changed without event");

    c_ctrl_wr: cover property (@(posedge hclk) st_reg.wr_pend && st_reg.wr_addr == RPR_OFS_CTRL);
    c_phase_upd: cover property (@(posedge hclk) st_reg.ph_cnt == 12'(RPR_PHASE_CYC - 1));
    c_frame: cover property (@(posedge hclk) header_detect ##[1:50] frame_end);
    c_flight: cover property (@(posedge hclk) flight_start ##[20:100] flight_stop);
endmodule // rpr_result_regs

// *** shared/rpr_pkg.sv ***
// Constants for the ranging and phase result register block.
// Behaviour
// (RULE_01) Correlator samples at plus 500, 750, 1000 ns. The 750 ns tap truncates to 187 cycles, so it samples at 748 ns.
// (RULE_02) Correlator registers full unsigned byte, reset zero.
// (RULE_03) First frequency offset after header detection.
// (RULE_04) Frame end replaces offset with accumulated value.
// (RULE_05) Offset is signed byte, minus to plus ninety.
// (RULE_06) Flight time 24 bits, low byte lowest address.
// (RULE_07) Flight counter increments at 16 MHz.
// (RULE_08) Phase delay versus internal low IF reference.
// (RULE_09) Control bit 5 enables phase mode, reset off.
// (RULE_10) Control bit 4 selects inverse IF position.
// (RULE_11) Phase result refreshes every 8 us when enabled.
// (RULE_12) Results visible only with view enable; writes ignored. The phase result reads without view enable.
package rpr_pkg;
    localparam logic [7:0] RPR_OFS_CTRL = 8'h03;
    localparam logic [7:0] RPR_OFS_PHASE = 8'h3b;
    localparam logic [7:0] RPR_OFS_CPM500 = 8'h79;
    localparam logic [7:0] RPR_OFS_CPM750 = 8'h7a;
    localparam logic [7:0] RPR_OFS_CPM1000 = 8'h7b;
    localparam logic [7:0] RPR_OFS_FEC = 8'h7c;
    localparam logic [7:0] RPR_OFS_TIM0 = 8'h7d;
    localparam logic [7:0] RPR_OFS_TIM1 = 8'h7e;
    localparam logic [7:0] RPR_OFS_TIM2 = 8'h7f;
    localparam logic [7:0] RPR_CTRL_RESET = 8'h09;
    localparam logic [7:0] RPR_CTRL_WMASK = 8'hbf;
    localparam int RPR_BIT_VIEW = 7;
    localparam int RPR_BIT_PHASE_EN = 5;
    localparam int RPR_BIT_IF_INV = 4;
    localparam int RPR_CLK_MHZ = 250;
    localparam int RPR_TICK_MHZ = 16;
    localparam int RPR_TICK_MILLI = RPR_CLK_MHZ * 1000 / RPR_TICK_MHZ;
    localparam int RPR_PHASE_US = 8;
    localparam int RPR_PHASE_CYC = RPR_PHASE_US * RPR_CLK_MHZ;
    localparam int RPR_SAMP_NS_0 = 500;
    localparam int RPR_SAMP_NS_1 = 750;
    localparam int RPR_SAMP_NS_2 = 1000;
    localparam int RPR_SAMP_CYC_0 = RPR_SAMP_NS_0 * RPR_CLK_MHZ / 1000;
    localparam int RPR_SAMP_CYC_1 = RPR_SAMP_NS_1 * RPR_CLK_MHZ / 1000;
    localparam int RPR_SAMP_CYC_2 = RPR_SAMP_NS_2 * RPR_CLK_MHZ / 1000;
endpackage

// *** rtl/rpr_sample_tap.sv ***
// One delayed capture of the correlator magnitude after the peak.
`timescale 1ns/100ps
module rpr_sample_tap
    import rpr_pkg::*;
#(
    parameter int DELAY = 125
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic peak,
    input wire logic [7:0] mag,
    output logic [7:0] sample
);
    typedef struct packed {
        logic busy;
        logic [9:0] cnt;
        logic [7:0] val;
    } rpr_tap_t;
    rpr_tap_t st_reg;
    rpr_tap_t st_next;

    always_comb begin
        st_next = st_reg;
        if (peak) begin
            st_next.busy = 1'b1;
            st_next.cnt = 10'h000;
        end else if (st_reg.busy) begin
            st_next.cnt = st_reg.cnt + 10'h001;
            if (st_reg.cnt == 10'(DELAY - 1)) begin
                st_next.busy = 1'b0;
                st_next.val = mag; // RULE_01
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0; // RULE_02
        end else begin
            st_reg <= st_next;
        end
    end

    assign sample = st_reg.val;

    a_tap_capture: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
        (peak ##1 (!peak) [*2]) |-> $stable(sample))
        else $error("tap changed too early after peak");
endmodule // rpr_sample_tap

// *** tb/rpr_result_regs_tb_top.sv ***
// Self-checking bench for the ranging and phase result registers.
`timescale 1ns/100ps
module rpr_result_regs_tb_top
    import rpr_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic sync_peak = 1'b0;
    logic header_detect = 1'b0;
    logic frame_end = 1'b0;
    logic flight_start = 1'b0;
    logic flight_stop = 1'b0;
    logic rx_phase = 1'b0;
    logic ref_phase = 1'b0;
    logic [7:0] corr_mag = 8'h00;
    logic [7:0] fov = 8'h00;
    logic hready, hresp, phase_unit_enable, phase_if_invert;
    logic [31:0] hrdata, rd;
    logic [7:0] a, b, c;
    logic [23:0] t, e;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int n;

    rpr_result_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .sync_peak(sync_peak),
        .corr_mag(corr_mag), .header_detect(header_detect), .frame_end(frame_end),
        .freq_offset_value(fov), .flight_start(flight_start), .flight_stop(flight_stop),
        .rx_phase(rx_phase), .ref_phase(ref_phase), .phase_unit_enable(phase_unit_enable),
        .phase_if_invert(phase_if_invert));

    initial begin
        forever #2 hclk = ~hclk;
    end

    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // A hung handshake would otherwise stall the run forever.
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single transfer; byte address is four times the register offset.
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    function automatic logic [23:0] exp_flight(input int cyc);
        return 24'(cyc * RPR_TICK_MHZ / RPR_CLK_MHZ);
    endfunction

    // A constant disagreement is counted once per eight cycles over the whole window.
    function automatic logic [7:0] exp_phase(input logic differ);
        return differ ? 8'(RPR_PHASE_CYC / 8) : 8'h00;
    endfunction

    task automatic tick(input int k);
        repeat (k) @(posedge hclk);
    endtask

    initial begin
        void'($urandom(49));
        tick(2);
        hresetn <= 1'b1;
        xfer(1'b0, RPR_OFS_CTRL, 32'h0);
        chk(rd, 32'h9);
        chk({30'h0, phase_unit_enable, phase_if_invert}, 32'h0);
        xfer(1'b0, RPR_OFS_PHASE, 32'h0);
        chk(rd, 32'h0);
        fov <= 8'($urandom);
        header_detect <= 1'b1;
        tick(1);
        header_detect <= 1'b0;
        xfer(1'b1, RPR_OFS_FEC, 32'h55);
        xfer(1'b0, RPR_OFS_FEC, 32'h0);
        chk(rd, 32'h0);
        $display("reset and gating test done");
        xfer(1'b1, RPR_OFS_CTRL, 32'hff);
        xfer(1'b0, RPR_OFS_CTRL, 32'h0);
        chk(rd, 32'hbf);
        chk({30'h0, phase_unit_enable, phase_if_invert}, 32'h3);
        xfer(1'b0, RPR_OFS_FEC, 32'h0);
        chk(rd, {24'h0, fov});
        xfer(1'b1, RPR_OFS_FEC, 32'h0);
        xfer(1'b0, RPR_OFS_FEC, 32'h0);
        chk(rd, {24'h0, fov});
        fov <= 8'h80 | 8'($urandom);
        frame_end <= 1'b1;
        tick(1);
        frame_end <= 1'b0;
        xfer(1'b0, RPR_OFS_FEC, 32'h0);
        chk(rd, {24'h0, fov});
        $display("control and offset test done");
        a = 8'($urandom);
        b = 8'hff;
        c = 8'($urandom);
        sync_peak <= 1'b1;
        for (int i = 1; i < 300; i++) begin
            tick(1);
            sync_peak <= 1'b0;
            corr_mag <= (i < 150) ? a : ((i < 215) ? b : c);
        end
        xfer(1'b0, RPR_OFS_CPM500, 32'h0);
        chk(rd, {24'h0, a});
        xfer(1'b0, RPR_OFS_CPM750, 32'h0);
        chk(rd, {24'h0, b});
        xfer(1'b0, RPR_OFS_CPM1000, 32'h0);
        chk(rd, {24'h0, c});
        $display("correlator test done");
        n = 2000 + ($urandom % 1000);
        flight_start <= 1'b1;
        tick(1);
        flight_start <= 1'b0;
        tick(n - 1);
        flight_stop <= 1'b1;
        tick(1);
        flight_stop <= 1'b0;
        xfer(1'b0, RPR_OFS_TIM0, 32'h0);
        t[7:0] = rd[7:0];
        xfer(1'b0, RPR_OFS_TIM1, 32'h0);
        t[15:8] = rd[7:0];
        xfer(1'b0, RPR_OFS_TIM2, 32'h0);
        t[23:16] = rd[7:0];
        e = exp_flight(n);
        // The tick accumulator clears at start, yet one count either way is still allowed.
        if (t == e + 24'h1 || t == e - 24'h1) begin
            e = t;
        end
        chk({8'h0, t}, {8'h0, e});
        $display("flight time test done");
        xfer(1'b1, RPR_OFS_CTRL, 32'ha9);
        tick(2 * RPR_PHASE_CYC + 20);
        xfer(1'b0, RPR_OFS_PHASE, 32'h0);
        chk(rd, {24'h0, exp_phase(1'b0)});
        rx_phase <= 1'b1;
        tick(2 * RPR_PHASE_CYC + 20);
        xfer(1'b0, RPR_OFS_PHASE, 32'h0);
        chk(rd, {24'h0, exp_phase(1'b1)});
        xfer(1'b1, RPR_OFS_CTRL, 32'hb9);
        tick(2 * RPR_PHASE_CYC + 20);
        xfer(1'b0, RPR_OFS_PHASE, 32'h0);
        chk(rd, {24'h0, exp_phase(1'b0)});
        chk({31'h0, phase_if_invert}, 32'h1);
        xfer(1'b0, 8'h50, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        $display("phase and unmapped test done");
        tally_and_finish();
    end
endmodule // rpr_result_regs_tb_top
